// [omw_pkg.sv]
// Package of constants and types for the operating mode and wake-up controller.
package omw_pkg;
    // ==================================================================
    // Oscillator control register
    // ==================================================================
    localparam logic [7:0] OMW_ADDR_OSC_MODE = 8'hCA;
    localparam int OMW_BIT_STOP = 1;
    localparam int OMW_BIT_SLOW = 2;
    localparam int OMW_BIT_SLEEP = 3;
    localparam int OMW_BIT_GREEN = 4;
    localparam logic [7:0] OMW_OSC_RESET = 8'h00;
    localparam logic [7:0] OMW_OSC_MASK = 8'h1E;
    localparam logic [7:0] OMW_UNMAPPED_READ = 8'h00;
    // ==================================================================
    // Stabilisation counts in high-speed oscillator cycles
    // ==================================================================
    localparam logic [11:0] OMW_XTAL_WAIT = 12'h800;
    localparam logic [11:0] OMW_RC_WAIT = 12'h008;
    localparam logic [11:0] OMW_ONE = 12'h001;
    localparam logic [1:0] OMW_SLOW_DIV = 2'h3;
    // ==================================================================
    // Modes
    // ==================================================================
    typedef enum logic [2:0] {
        OMW_NORMAL,
        OMW_SLOW,
        OMW_GREEN,
        OMW_POWER_DOWN,
        OMW_WARMUP
    } omw_mode_e;
endpackage

// [omw_mode_control.sv]
// Operating mode sequencer with oscillator gating and wake-up handling.
// Summary of operation
// - Reset release enters normal mode, executing.
// - Slow select bit picks low-speed system clock.
// - Slow mode instruction rate is low clock/4.
// - Slow mode keeps high oscillator unless stopped.
// - Sleep request halts CPU, stops all oscillators.
// - Power-down wake clears sleep request bit.
// - Power-down wakes on port/reset, resumes normal.
// - Green request halts CPU, keeps clock running.
// - Green wake clears green request bit.
// - Green wake returns to the mode left.
// - Green wakes on port, timer zero, reset.
// - Green wake resumes without stabilisation delay.
// - Crystal power-down wake waits 2048 cycles.
// - RC power-down wake waits 8 cycles.
// - Low RC runs except in power-down.
// - Green keeps PWM/buzzer; only enabled timer wakes.
// - Stop bit in normal mode acts as power-down.
// - Watchdog enable follows configuration option only.
// - Mode field bits 4:3: normal, sleep, green.
// - Stop bit 1 stops selected high oscillator.
// - Slow bit 2; register fields reset zero.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module omw_mode_control (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic highOscIsCrystal,
    input wire logic highOscTick,
    input wire logic lowOscTick,
    input wire logic wakePortChange,
    input wire logic timerZeroOverflow,
    input wire logic timerZeroGreenWake,
    input wire logic timerZeroEnable,
    input wire logic timerOneEnable,
    input wire logic watchdogOption,
    output logic extHighOscRun,
    output logic intHighRcRun,
    output logic intLowRcRun,
    output logic sysClkIsLow,
    output logic cpuRun,
    output logic cpuInstrTick,
    output logic timerZeroRun,
    output logic timerOneRun,
    output logic watchdogRun,
    output omw_pkg::omw_mode_e modeState
);
    import omw_pkg::*;

    typedef struct packed {
        omw_mode_e mode;
        omw_mode_e greenReturn;
        logic stopHigh;
        logic slowSel;
        logic sleepReq;
        logic greenReq;
        logic [11:0] waitCount;
        logic [1:0] slowDiv;
        logic [7:0] rdData;
        logic extRun;
        logic intRun;
        logic lowRun;
        logic clkLow;
        logic cpu;
        logic instrTick;
        logic t0Run;
        logic t1Run;
        logic wdRun;
    } omw_state_s;

    omw_state_s st;
    omw_state_s next_st;

    function automatic logic [7:0] packOsc(input omw_state_s s);
        logic [7:0] v;
        v = OMW_OSC_RESET;
        v[OMW_BIT_STOP] = s.stopHigh;
        v[OMW_BIT_SLOW] = s.slowSel;
        v[OMW_BIT_SLEEP] = s.sleepReq;
        v[OMW_BIT_GREEN] = s.greenReq;
        return v & OMW_OSC_MASK;
    endfunction

    // ==================================================================
    // Next-state logic
    // ==================================================================
    always_comb begin
        logic hit;
        logic highOn;
        hit = 1'b0;
        highOn = 1'b0;
        next_st = st;
        next_st.instrTick = 1'b0;
        hit = (regAddr == OMW_ADDR_OSC_MODE);
        next_st.rdData = OMW_UNMAPPED_READ;
        if (regRead && hit) begin
            next_st.rdData = packOsc(st);
        end
        // Software writes only take effect while the CPU runs; a halted core issues none.
        // mode field decode
        if (regWrite && hit && (st.mode == OMW_NORMAL || st.mode == OMW_SLOW)) begin
            next_st.stopHigh = regWrData[OMW_BIT_STOP];
            next_st.slowSel = regWrData[OMW_BIT_SLOW];
            next_st.sleepReq = regWrData[OMW_BIT_SLEEP];
            next_st.greenReq = regWrData[OMW_BIT_GREEN] & ~regWrData[OMW_BIT_SLEEP];
        end
        case (st.mode)
            OMW_NORMAL, OMW_SLOW: begin
                if (next_st.sleepReq) begin
                    next_st.mode = OMW_POWER_DOWN;
                end else if (next_st.greenReq) begin
                    next_st.greenReturn = st.mode;
                    next_st.mode = OMW_GREEN;
                end else if (next_st.stopHigh && !next_st.slowSel) begin
                    next_st.mode = OMW_POWER_DOWN;
                end else if (next_st.slowSel) begin
                    next_st.mode = OMW_SLOW;
                end else begin
                    next_st.mode = OMW_NORMAL;
                end
            end
            OMW_GREEN: begin
                if (wakePortChange || (timerZeroOverflow && timerZeroGreenWake)) begin
                    next_st.greenReq = 1'b0;
                    // return to prior mode, with no delay
                    next_st.mode = st.greenReturn;
                end
            end
            OMW_POWER_DOWN: begin
                if (wakePortChange) begin
                    next_st.sleepReq = 1'b0;
                    next_st.slowSel = 1'b0;
                    next_st.stopHigh = 1'b0;
                    next_st.waitCount = highOscIsCrystal ? OMW_XTAL_WAIT : OMW_RC_WAIT;
                    next_st.mode = OMW_WARMUP;
                end
            end
            OMW_WARMUP: begin
                if (highOscTick) begin
                    next_st.waitCount = st.waitCount - OMW_ONE;
                    if (st.waitCount == OMW_ONE) begin
                        next_st.mode = OMW_NORMAL;
                    end
                end
            end
            default: begin
                next_st.mode = OMW_NORMAL;
            end
        endcase
        // Oscillator and execution gating follow the settled mode.
        // stop bit gates selected high oscillator
        highOn = 1'b1;
        case (next_st.mode)
            OMW_POWER_DOWN: highOn = 1'b0;
            OMW_WARMUP: highOn = 1'b1;
            OMW_SLOW: highOn = ~next_st.stopHigh;
            OMW_GREEN: highOn = (next_st.greenReturn == OMW_NORMAL) | ~next_st.stopHigh;
            default: highOn = 1'b1;
        endcase
        next_st.extRun = highOn & highOscIsCrystal;
        next_st.intRun = highOn & ~highOscIsCrystal;
        // low RC stops only in power-down
        next_st.lowRun = (next_st.mode != OMW_POWER_DOWN);
        next_st.clkLow = (next_st.mode == OMW_SLOW) ||
            (next_st.mode == OMW_GREEN && next_st.greenReturn == OMW_SLOW);
        // execution in normal and slow only
        next_st.cpu = (next_st.mode == OMW_NORMAL) || (next_st.mode == OMW_SLOW);
        // timers follow own enable in green
        next_st.t0Run = timerZeroEnable && (next_st.mode != OMW_POWER_DOWN)
            && (next_st.mode != OMW_WARMUP);
        next_st.t1Run = timerOneEnable && (next_st.mode != OMW_POWER_DOWN)
            && (next_st.mode != OMW_WARMUP);
        next_st.wdRun = watchdogOption;
        // slow instruction rate divide by four
        if (st.mode == OMW_SLOW && lowOscTick) begin
            next_st.slowDiv = st.slowDiv + 2'h1;
            next_st.instrTick = (st.slowDiv == OMW_SLOW_DIV);
        end else if (st.mode == OMW_NORMAL) begin
            next_st.slowDiv = 2'h0;
            next_st.instrTick = 1'b1;
        end
    end

    // ==================================================================
    // State register
    // ==================================================================
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{mode: OMW_NORMAL, greenReturn: OMW_NORMAL, stopHigh: 1'b0,
                slowSel: 1'b0, sleepReq: 1'b0, greenReq: 1'b0, waitCount: 12'h000,
                slowDiv: 2'h0, rdData: 8'h00, extRun: 1'b0, intRun: 1'b0,
                lowRun: 1'b1, clkLow: 1'b0, cpu: 1'b1, instrTick: 1'b0,
                t0Run: 1'b0, t1Run: 1'b0, wdRun: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign regRdData = st.rdData;
    assign extHighOscRun = st.extRun;
    assign intHighRcRun = st.intRun;
    assign intLowRcRun = st.lowRun;
    assign sysClkIsLow = st.clkLow;
    assign cpuRun = st.cpu;
    assign cpuInstrTick = st.instrTick;
    assign timerZeroRun = st.t0Run;
    assign timerOneRun = st.t1Run;
    assign watchdogRun = st.wdRun;
    assign modeState = st.mode;
endmodule

// [omw_mode_control_asserts.sv]
// Port-level assertion checker for the operating mode controller.
`timescale 1ns/1ps
module omw_mode_control_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic highOscIsCrystal,
    input wire logic highOscTick,
    input wire logic wakePortChange,
    input wire logic timerZeroOverflow,
    input wire logic timerZeroGreenWake,
    input wire logic watchdogOption,
    input wire logic extHighOscRun,
    input wire logic intHighRcRun,
    input wire logic intLowRcRun,
    input wire logic sysClkIsLow,
    input wire logic cpuRun,
    input wire logic watchdogRun,
    input wire omw_pkg::omw_mode_e modeState
);
    import omw_pkg::*;
    // ==========================================
    // Warm-up tick counter
    // ==========================================
    logic [11:0] warmTicks;
    wire wrOsc = regWrite && regAddr == OMW_ADDR_OSC_MODE;
    wire runMode = modeState == OMW_NORMAL || modeState == OMW_SLOW;
    // Cleared outside warm-up, so ticks seen in power-down cannot shorten the wait.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            warmTicks <= 12'h000;
        end else begin
            warmTicks <= (modeState == OMW_WARMUP) ? warmTicks + {11'h000, highOscTick} : 12'h000;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_warm_exit;
        modeState == OMW_WARMUP ##1 modeState == OMW_NORMAL;
    endsequence
    sequence s_green_wake;
        modeState == OMW_GREEN && (wakePortChange || timerZeroOverflow && timerZeroGreenWake);
    endsequence
    a_run_modes: assert property (runMode |-> cpuRun && intLowRcRun)
        else $error("run mode without cpu or low clock");
    a_pd_stops: assert property (modeState == OMW_POWER_DOWN |->
        !(cpuRun || extHighOscRun || intHighRcRun || intLowRcRun)) else $error("power-down runs");
    a_sleep_enter: assert property (wrOsc && regWrData[3] && runMode |=>
        modeState == OMW_POWER_DOWN) else $error("sleep write ignored");
    a_slow_keep: assert property (wrOsc && regWrData[4:1] == 4'h2 && runMode |=>
        sysClkIsLow && (extHighOscRun || intHighRcRun)) else $error("slow entry wrong");
    a_pd_wake: assert property (modeState == OMW_POWER_DOWN |=>
        modeState == ($past(wakePortChange) ? OMW_WARMUP : OMW_POWER_DOWN)) else $error("pd wake");
    a_green_wake: assert property (s_green_wake |=>
        modeState == ($past(sysClkIsLow) ? OMW_SLOW : OMW_NORMAL)) else $error("green wake");
    a_warm_count: assert property (s_warm_exit |->
        warmTicks == (highOscIsCrystal ? OMW_XTAL_WAIT : OMW_RC_WAIT)) else $error("warm-up count");
    a_wdog_follow: assert property ($stable(watchdogOption) ##1 $stable(watchdogOption) |->
        watchdogRun == watchdogOption) else $error("watchdog run mismatch");
endmodule
bind omw_mode_control omw_mode_control_asserts omw_mode_control_asserts_inst (.clk_sys, .rst_n,
    .regAddr, .regWrData, .regWrite, .highOscIsCrystal, .highOscTick, .wakePortChange,
    .timerZeroOverflow, .timerZeroGreenWake, .watchdogOption, .extHighOscRun, .intHighRcRun,
    .intLowRcRun, .sysClkIsLow, .cpuRun, .watchdogRun, .modeState);

// [testbench.sv]
// Directed bench for the operating mode controller.
`timescale 1ns/1ps
module testbench;
    import omw_pkg::*;
    logic clk_sys = 1'h0, rst_n = 1'h0, regWrite = 1'h0, regRead = 1'h0, wakePortChange = 1'h0;
    logic highOscIsCrystal = 1'h0, highOscTick = 1'h0, lowOscTick = 1'h0, watchdogOption = 1'h0;
    logic timerZeroOverflow = 1'h0, timerZeroGreenWake = 1'h0;
    logic timerZeroEnable = 1'h1, timerOneEnable = 1'h0;
    logic timerZeroRun, timerOneRun, cpuInstrTick;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic extHighOscRun, intHighRcRun, intLowRcRun, sysClkIsLow, cpuRun, watchdogRun;
    omw_mode_e modeState;
    int miscompares = 0;
    int num_checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    // Ticks every other cycle, so the edge after the last counted tick never carries another.
    always @(posedge clk_sys) highOscTick <= ~highOscTick;
    always @(posedge clk_sys) lowOscTick <= ~lowOscTick;
    omw_mode_control omw_mode_control_inst (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrite,
        .regRead, .regRdData, .highOscIsCrystal, .highOscTick, .lowOscTick, .wakePortChange,
        .timerZeroOverflow, .timerZeroGreenWake, .timerZeroEnable, .timerOneEnable,
        .watchdogOption, .extHighOscRun, .intHighRcRun, .intLowRcRun, .sysClkIsLow, .cpuRun,
        .cpuInstrTick, .timerZeroRun, .timerOneRun, .watchdogRun, .modeState);
    // ==========================================
    // Access and check tasks
    // ==========================================
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic md(input omw_mode_e exp);
        chk("mode", {5'h00, exp}, {5'h00, modeState});
    endtask
    task automatic wr(input logic [7:0] data);
        @(posedge clk_sys);
        regAddr <= OMW_ADDR_OSC_MODE;
        regWrData <= data;
        regWrite <= 1'h1;
        @(posedge clk_sys);
        regWrite <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk_sys);
        regAddr <= addr;
        regRead <= 1'h1;
        @(posedge clk_sys);
        regRead <= 1'h0;
        #1;
        chk("read", exp, regRdData);
    endtask
    task automatic pulse(input logic port);
        @(posedge clk_sys);
        wakePortChange <= port;
        timerZeroOverflow <= !port;
        @(posedge clk_sys);
        wakePortChange <= 1'h0;
        timerZeroOverflow <= 1'h0;
        #1;
    endtask
    task automatic sleep_wake(input logic [7:0] data);
        int n;
        n = 0;
        wr(data);
        md(OMW_POWER_DOWN);
        chk("osc", 8'h00, {5'h00, extHighOscRun, intHighRcRun, intLowRcRun});
        chk("timer zero run", 8'h00, {7'h00, timerZeroRun});
        pulse(1'h0);
        md(OMW_POWER_DOWN);
        pulse(1'h1);
        md(OMW_WARMUP);
        while (modeState !== OMW_NORMAL && n < 5000) begin
            @(posedge clk_sys);
            n++;
        end
        #1;
        md(OMW_NORMAL);
        rd(OMW_ADDR_OSC_MODE, 8'h00);
    endtask
    initial begin
        int ticks;
        ticks = 0;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n <= 1'h1;
        rd(OMW_ADDR_OSC_MODE, OMW_OSC_RESET);
        md(OMW_NORMAL);
        chk("instr tick", 8'h01, {7'h00, cpuInstrTick});
        rd(8'h55, OMW_UNMAPPED_READ);
        $display("test reset done");
        wr(8'h04);
        md(OMW_SLOW);
        chk("high osc", 8'h01, {7'h00, intHighRcRun});
        // The low tick toggles each cycle, so a slot falls every eight cycles.
        repeat (32) begin
            @(posedge clk_sys);
            #1;
            ticks += cpuInstrTick;
        end
        chk("instr ticks", 8'h04, ticks[7:0]);
        wr(8'h14);
        md(OMW_GREEN);
        chk("cpu run", 8'h00, {7'h00, cpuRun});
        chk("timer zero run", 8'h01, {7'h00, timerZeroRun});
        chk("timer one run", 8'h00, {7'h00, timerOneRun});
        pulse(1'h0);
        md(OMW_GREEN);
        timerZeroGreenWake <= 1'h1;
        pulse(1'h0);
        md(OMW_SLOW);
        rd(OMW_ADDR_OSC_MODE, 8'h04);
        wr(8'h06);
        chk("high osc", 8'h00, {7'h00, intHighRcRun});
        $display("test slow green done");
        sleep_wake(8'h1E);
        wr(8'h10);
        pulse(1'h1);
        md(OMW_NORMAL);
        watchdogOption <= 1'h1;
        highOscIsCrystal <= 1'h1;
        sleep_wake(8'h02);
        chk("watchdog", 8'h01, {7'h00, watchdogRun});
        $display("test sleep done");
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end
endmodule
